// ===== plc_map.svh
`ifndef PLC_MAP_SVH
`define PLC_MAP_SVH

// ***********************************
// Register offsets, bus answers
// ***********************************
`define PLC_CAP_OFF 12'h00c
`define PLC_CTRL_OFF 12'h010
`define PLC_RESP_OKAY 2'h0
`define PLC_RESP_SLVERR 2'h2

// ***********************************
// Link control bit positions and reset value
// ***********************************
`define PLC_B_AWD 9
`define PLC_B_CPME 8
`define PLC_B_EXT_SYNCH 7
`define PLC_B_COMMON_CLK 6
`define PLC_B_RD_BOUND 3
`define PLC_B_ASPM_HI 1
`define PLC_B_ASPM_LO 0
`define PLC_CTRL_RST 7'h00

// ***********************************
// Capability positions that read zero
// ***********************************
`define PLC_CAP_Z_HI 21
`define PLC_CAP_Z_LO 19

`endif

// ===== plc_pkg.sv
package plc_pkg;

    // Link control fields handed to the link logic
    typedef struct packed {
        logic aw_dis;
        logic clk_pm_en;
        logic ext_synch;
        logic common_clk;
        logic rd_bound;
        logic [1:0] aspm;
    } plc_ctrl_t;

    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_CAP = 2'b01,
        SEL_CTRL = 2'b10
    } plc_sel_t;

endpackage : plc_pkg

// ===== plc_regs.sv
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "plc_map.svh"

module plc_regs #(
    parameter logic [7:0] PORT_NUM = 8'h00,
    parameter logic ASPM_OPT_COMPL = 1'b1,
    parameter logic CLK_PM_CAPABLE = 1'b0,
    parameter logic [2:0] L1_EXIT_LAT = 3'h0,
    parameter logic [2:0] L0S_EXIT_LAT = 3'h0,
    parameter logic [1:0] ASPM_SUPPORT = 2'h0,
    parameter logic [5:0] MAX_WIDTH = 6'h01,
    parameter logic [3:0] LINK_SPEEDS = 4'h1,
    parameter logic AUTO_WIDTH_IMPL = 1'b1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pm_clk_release,
    input wire logic width_req,
    input wire logic width_reduce_fix,
    output logic width_grant,
    output logic clkreq_n,
    output plc_pkg::plc_ctrl_t link_ctrl
);
    import plc_pkg::*;

    // ***********************************
    // Address decode
    // ***********************************
    function automatic plc_sel_t plc_decode(input logic [11:0] addr);
        logic [11:0] wa;
        wa = {addr[11:2], 2'b00};
        if (wa == `PLC_CAP_OFF) begin
            plc_decode = SEL_CAP;
        end else if (wa == `PLC_CTRL_OFF) begin
            plc_decode = SEL_CTRL;
        end else begin
            plc_decode = SEL_NONE;
        end
    endfunction : plc_decode

    // ***********************************
    // State
    // ***********************************
    plc_ctrl_t ctrl_ff;
    plc_ctrl_t nxt_ctrl;
    logic awready_ff;
    logic wready_ff;
    logic aw_got_ff;
    logic w_got_ff;
    logic [11:0] awaddr_ff;
    logic [15:0] wdata_ff;
    logic [1:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic clkreq_n_ff;
    logic width_grant_ff;

    // ***********************************
    // Write channel control
    // ***********************************
    wire aw_take = s_axi_awvalid & awready_ff;
    wire w_take = s_axi_wvalid & wready_ff;
    wire wr_do = aw_got_ff & w_got_ff & ~bvalid_ff;
    wire nxt_aw_got = (aw_got_ff & ~wr_do) | aw_take;
    wire nxt_w_got = (w_got_ff & ~wr_do) | w_take;
    wire nxt_bvalid = wr_do | (bvalid_ff & ~s_axi_bready);
    wire nxt_awready = ~nxt_aw_got & ~nxt_bvalid;
    wire nxt_wready = ~nxt_w_got & ~nxt_bvalid;
    wire plc_sel_t wr_sel = plc_decode(awaddr_ff);
    wire wr_ctrl = wr_do & (wr_sel == SEL_CTRL);
    wire [1:0] nxt_bresp = (wr_sel == SEL_NONE) ? `PLC_RESP_SLVERR : `PLC_RESP_OKAY;

    // ***********************************
    // Read channel control
    // ***********************************
    wire ar_take = s_axi_arvalid & arready_ff;
    wire nxt_rvalid = ar_take | (rvalid_ff & ~s_axi_rready);
    wire nxt_arready = ~nxt_rvalid;
    wire plc_sel_t rd_sel = plc_decode(s_axi_araddr);

    // ***********************************
    // Register images
    // ***********************************
    wire [31:0] cap_word = {
        PORT_NUM,
        1'b0,
        ASPM_OPT_COMPL,
        3'b000,
        CLK_PM_CAPABLE,
        L1_EXIT_LAT,
        L0S_EXIT_LAT,
        ASPM_SUPPORT,
        MAX_WIDTH,
        LINK_SPEEDS
    };
    // Reserved control bits are wired zero, never stored
    wire [31:0] ctrl_word = {
        16'h0000,
        6'h00,
        ctrl_ff.aw_dis,
        ctrl_ff.clk_pm_en,
        ctrl_ff.ext_synch,
        ctrl_ff.common_clk,
        2'b00,
        ctrl_ff.rd_bound,
        1'b0,
        ctrl_ff.aspm
    };
    wire [31:0] nxt_rdata = (rd_sel == SEL_CAP) ? cap_word :
                            (rd_sel == SEL_CTRL) ? ctrl_word : 32'h0000_0000;
    wire [1:0] nxt_rresp = (rd_sel == SEL_NONE) ? `PLC_RESP_SLVERR : `PLC_RESP_OKAY;

    // ***********************************
    // Link control update
    // ***********************************
    // Only writable fields are taken; capability writes and reserved
    // bits fall away here, with per-byte strobes honoured
    wire wr_lo = wr_ctrl & wstrb_ff[0];
    wire wr_hi = wr_ctrl & wstrb_ff[1];
    // Width disable stays zero when autonomous width change is absent
    assign nxt_ctrl.aw_dis = AUTO_WIDTH_IMPL &
        (wr_hi ? wdata_ff[`PLC_B_AWD] : ctrl_ff.aw_dis);
    assign nxt_ctrl.clk_pm_en = wr_hi ? wdata_ff[`PLC_B_CPME] : ctrl_ff.clk_pm_en;
    assign nxt_ctrl.ext_synch = wr_lo ? wdata_ff[`PLC_B_EXT_SYNCH] : ctrl_ff.ext_synch;
    assign nxt_ctrl.common_clk = wr_lo ? wdata_ff[`PLC_B_COMMON_CLK] : ctrl_ff.common_clk;
    assign nxt_ctrl.rd_bound = wr_lo ? wdata_ff[`PLC_B_RD_BOUND] : ctrl_ff.rd_bound;
    assign nxt_ctrl.aspm = wr_lo ?
        wdata_ff[`PLC_B_ASPM_HI:`PLC_B_ASPM_LO] : ctrl_ff.aspm;

    // ***********************************
    // Link-side decisions
    // ***********************************
    // Clock may only be released when enabled and the part tolerates it
    wire nxt_clkreq_n = ctrl_ff.clk_pm_en & CLK_PM_CAPABLE & pm_clk_release;
    // Width changes pass unless disabled and not a reliability reduction
    wire nxt_width_grant = width_req & (~ctrl_ff.aw_dis | width_reduce_fix);

    // ***********************************
    // Flip-flops
    // ***********************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
        end else begin
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            aw_got_ff <= nxt_aw_got;
            w_got_ff <= nxt_w_got;
            bvalid_ff <= nxt_bvalid;
            arready_ff <= nxt_arready;
            rvalid_ff <= nxt_rvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_ff <= 12'h000;
            wdata_ff <= 16'h0000;
            wstrb_ff <= 2'h0;
        end else begin
            if (aw_take) begin
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_ff <= s_axi_wdata[15:0];
                wstrb_ff <= s_axi_wstrb[1:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bresp_ff <= `PLC_RESP_OKAY;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `PLC_RESP_OKAY;
        end else begin
            if (wr_do) begin
                bresp_ff <= nxt_bresp;
            end
            if (ar_take) begin
                rdata_ff <= nxt_rdata;
                rresp_ff <= nxt_rresp;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= `PLC_CTRL_RST;
            clkreq_n_ff <= 1'b0;
            width_grant_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            clkreq_n_ff <= nxt_clkreq_n;
            width_grant_ff <= nxt_width_grant;
        end
    end

    // ***********************************
    // Outputs
    // ***********************************
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign clkreq_n = clkreq_n_ff;
    assign width_grant = width_grant_ff;
    // Extended synch and common clock go to the transmitter as is
    assign link_ctrl = ctrl_ff;

    // ***********************************
    // Assertions
    // ***********************************
    a_clkreq_low: assert property (@(posedge aclk) disable iff (!aresetn)
        !ctrl_ff.clk_pm_en |=> !clkreq_n_ff)
        else $error("clock request released while disabled");

    a_clkreq_use: assert property (@(posedge aclk) disable iff (!aresetn)
        (ctrl_ff.clk_pm_en && CLK_PM_CAPABLE && pm_clk_release) |=> clkreq_n_ff)
        else $error("clock request not released when permitted");

    a_cpm_never: assert property (@(posedge aclk) disable iff (!aresetn)
        clkreq_n_ff |-> CLK_PM_CAPABLE && $past(ctrl_ff.clk_pm_en) && $past(pm_clk_release))
        else $error("clock released by a part that cannot tolerate it");

    a_width_guard: assert property (@(posedge aclk) disable iff (!aresetn)
        (width_req && ctrl_ff.aw_dis && !width_reduce_fix) |=> !width_grant_ff)
        else $error("width change granted while disabled");

    a_width_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_ff.aw_dis |-> AUTO_WIDTH_IMPL)
        else $error("width disable set without autonomous width");

    a_cap_read: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_take && rd_sel == SEL_CAP) |=>
            rvalid_ff && s_axi_rdata == cap_word &&
            s_axi_rdata[`PLC_CAP_Z_HI:`PLC_CAP_Z_LO] == 3'b000)
        else $error("capability read returned wrong word");

    a_ctrl_resv: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_take && rd_sel == SEL_CTRL) |=>
            s_axi_rdata[31:10] == 22'h000000 && s_axi_rdata[5:4] == 2'b00 &&
            !s_axi_rdata[2])
        else $error("reserved control bits read nonzero");

    a_ro_write: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_do && wr_sel != SEL_CTRL) |=> $stable(ctrl_ff))
        else $error("write outside link control changed it");

    a_ctrl_write: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_ctrl && wstrb_ff[0]) |=>
            ctrl_ff.aspm == $past(wdata_ff[1:0]) &&
            ctrl_ff.rd_bound == $past(wdata_ff[3]) &&
            link_ctrl.common_clk == $past(wdata_ff[6]) &&
            link_ctrl.ext_synch == $past(wdata_ff[7]))
        else $error("link control low byte not written");

    a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (bvalid_ff && !s_axi_bready) |=> bvalid_ff && $stable(bresp_ff))
        else $error("write response dropped before taken");

    a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        (aw_got_ff && w_got_ff && !bvalid_ff) |=> bvalid_ff)
        else $error("write response late");

    // ***********************************
    // Bus, field and width grant assertions
    // ***********************************
    a_bus_reopen: assert property (@(posedge aclk) disable iff (!aresetn)
        (bvalid_ff && s_axi_bready) |=> !bvalid_ff && awready_ff && wready_ff)
        else $error("write channels not reopened");

    a_aw_closed: assert property (@(posedge aclk) disable iff (!aresetn)
        bvalid_ff |-> !awready_ff && !wready_ff)
        else $error("write channels open during response");

    a_wr_error: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_do && wr_sel == SEL_NONE) |=> bvalid_ff && bresp_ff == `PLC_RESP_SLVERR)
        else $error("unmapped write not refused");

    a_wr_okay: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_do && wr_sel != SEL_NONE) |=> bresp_ff == `PLC_RESP_OKAY)
        else $error("mapped write refused");

    a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_take |=> rvalid_ff && !arready_ff)
        else $error("read answer late");

    a_read_reopen: assert property (@(posedge aclk) disable iff (!aresetn)
        (rvalid_ff && s_axi_rready) |=> !rvalid_ff && arready_ff)
        else $error("read channel not reopened");

    a_rd_error: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_take && rd_sel == SEL_NONE) |=>
            rresp_ff == `PLC_RESP_SLVERR && rdata_ff == 32'h0000_0000)
        else $error("unmapped read not refused");

    a_cap_port: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_take && rd_sel == SEL_CAP) |=>
            rdata_ff[31:24] == PORT_NUM && !rdata_ff[23])
        else $error("port number field wrong");

    a_cap_flags: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_take && rd_sel == SEL_CAP) |=>
            rdata_ff[22] == ASPM_OPT_COMPL && rdata_ff[18] == CLK_PM_CAPABLE)
        else $error("capability flags wrong");

    a_cap_latency: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_take && rd_sel == SEL_CAP) |=>
            rdata_ff[17:15] == L1_EXIT_LAT && rdata_ff[14:12] == L0S_EXIT_LAT)
        else $error("exit latency fields wrong");

    a_cap_link: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_take && rd_sel == SEL_CAP) |=>
            rdata_ff[11:10] == ASPM_SUPPORT && rdata_ff[9:4] == MAX_WIDTH &&
            rdata_ff[3:0] == LINK_SPEEDS)
        else $error("link capability fields wrong");

    a_ctrl_high: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_ctrl && wstrb_ff[1]) |=>
            ctrl_ff.clk_pm_en == $past(wdata_ff[`PLC_B_CPME]) &&
            ctrl_ff.aw_dis == (AUTO_WIDTH_IMPL && $past(wdata_ff[`PLC_B_AWD])))
        else $error("link control high byte not written");

    a_low_keep: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_ctrl && !wstrb_ff[0]) |=>
            $stable(ctrl_ff.aspm) && $stable(ctrl_ff.rd_bound) &&
            $stable(ctrl_ff.ext_synch) && $stable(ctrl_ff.common_clk))
        else $error("masked low byte changed");

    a_high_keep: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_ctrl && !wstrb_ff[1]) |=>
            $stable(ctrl_ff.aw_dis) && $stable(ctrl_ff.clk_pm_en))
        else $error("masked high byte changed");

    a_ctrl_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        !wr_ctrl |=> $stable(ctrl_ff))
        else $error("link control changed without a write");

    a_width_pass: assert property (@(posedge aclk) disable iff (!aresetn)
        (width_req && (!ctrl_ff.aw_dis || width_reduce_fix)) |=> width_grant_ff)
        else $error("permitted width change not granted");

    a_width_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        !width_req |=> !width_grant_ff)
        else $error("width granted without request");

endmodule : plc_regs

// ===== tb_top.sv
`timescale 1ns/10ps
`include "plc_map.svh"

module tb_top;
    import plc_pkg::*;
    // ***********************************
    // Straps, chosen away from defaults
    // ***********************************
    localparam logic [7:0] PORT_ID = 8'h5a;
    localparam logic [2:0] L1L = 3'h5;
    localparam logic [2:0] L0L = 3'h3;
    localparam logic [1:0] ASP = 2'h2;
    localparam logic [5:0] MW = 6'h10;
    localparam logic [3:0] LS = 4'h6;
    localparam logic [31:0] CAP_EXP = {PORT_ID, 2'b01, 3'h0, 1'b1, L1L, L0L, ASP, MW, LS};

    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, width_grant, clkreq_n;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic pm_clk_release = 1'b0, width_req = 1'b0, width_reduce_fix = 1'b0;
    plc_ctrl_t link_ctrl;
    int n_mismatch = 0;
    int samples_checked = 0;

    always #25 aclk = ~aclk;

    plc_regs #(.PORT_NUM(PORT_ID), .ASPM_OPT_COMPL(1'b1), .CLK_PM_CAPABLE(1'b1),
        .L1_EXIT_LAT(L1L),
        .L0S_EXIT_LAT(L0L), .ASPM_SUPPORT(ASP), .MAX_WIDTH(MW), .LINK_SPEEDS(LS),
        .AUTO_WIDTH_IMPL(1'b1)) dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pm_clk_release(pm_clk_release), .width_req(width_req),
        .width_reduce_fix(width_reduce_fix), .width_grant(width_grant), .clkreq_n(clkreq_n),
        .link_ctrl(link_ctrl));

    // ***********************************
    // Shared tasks
    // ***********************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t %s got %h want %h", $time, m, got, exp);
        end
    endtask : chk

    // Valid values are sampled here before this edge's own updates land
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] exp_resp);
        int n;
        @(posedge aclk);
        awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s; wvalid <= 1'b1; bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                bready <= 1'b0;
                chk({30'h0, bresp}, {30'h0, exp_resp}, "write response");
                break;
            end
        end
        if (n == 40) chk(32'h1, 32'h0, "write hang");
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
        int n;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rready <= 1'b0;
                chk(rdata, exp, "read data");
                chk({30'h0, rresp}, {30'h0, exp_resp}, "read response");
                break;
            end
        end
        if (n == 40) chk(32'h1, 32'h0, "read hang");
    endtask : rd

    // Link inputs held steady, so two edges settle the registered answer
    task automatic link(input logic rel, input logic req, input logic fix);
        @(posedge aclk);
        pm_clk_release <= rel; width_req <= req; width_reduce_fix <= fix;
        repeat (2) @(posedge aclk);
    endtask : link

    // ***********************************
    // Scenarios
    // ***********************************
    task automatic t_ctrl();
        rd(`PLC_CTRL_OFF, 32'h0, `PLC_RESP_OKAY);
        wr(`PLC_CTRL_OFF, 32'hffff_ffff, 4'hf, `PLC_RESP_OKAY);
        rd(`PLC_CTRL_OFF, 32'h0000_03cb, `PLC_RESP_OKAY);
        chk({25'h0, link_ctrl}, 32'h7f, "link fields all set");
        chk({31'h0, link_ctrl.common_clk}, 32'h1, "common clock flag");
        wr(`PLC_CTRL_OFF, 32'h0, 4'h2, `PLC_RESP_OKAY);
        rd(`PLC_CTRL_OFF, 32'h0000_00cb, `PLC_RESP_OKAY);
        wr(`PLC_CTRL_OFF, 32'h0, 4'h1, `PLC_RESP_OKAY);
        rd(`PLC_CTRL_OFF, 32'h0, `PLC_RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            wr(`PLC_CTRL_OFF, 32'h8 | i, 4'hf, `PLC_RESP_OKAY);
            rd(`PLC_CTRL_OFF, 32'h8 | i, `PLC_RESP_OKAY);
            chk({25'h0, link_ctrl}, 32'h4 | i, "power level on link side");
        end
    endtask : t_ctrl

    task automatic t_cap();
        rd(`PLC_CAP_OFF, CAP_EXP, `PLC_RESP_OKAY);
        wr(`PLC_CAP_OFF, 32'hffff_ffff, 4'hf, `PLC_RESP_OKAY);
        rd(`PLC_CAP_OFF, CAP_EXP, `PLC_RESP_OKAY);
        rd(`PLC_CTRL_OFF, 32'hb, `PLC_RESP_OKAY);
    endtask : t_cap

    task automatic t_unmapped();
        wr(12'h014, 32'hffff_ffff, 4'hf, `PLC_RESP_SLVERR);
        rd(12'h014, 32'h0, `PLC_RESP_SLVERR);
        rd(`PLC_CTRL_OFF, 32'hb, `PLC_RESP_OKAY);
    endtask : t_unmapped

    task automatic t_clkreq();
        wr(`PLC_CTRL_OFF, 32'h0, 4'hf, `PLC_RESP_OKAY);
        link(1'b1, 1'b0, 1'b0);
        chk({31'h0, clkreq_n}, 32'h0, "clock request held low");
        wr(`PLC_CTRL_OFF, 32'h100, 4'hf, `PLC_RESP_OKAY);
        link(1'b1, 1'b0, 1'b0);
        chk({31'h0, clkreq_n}, 32'h1, "clock request released");
        link(1'b0, 1'b0, 1'b0);
        chk({31'h0, clkreq_n}, 32'h0, "clock request asserted");
    endtask : t_clkreq

    task automatic t_width();
        wr(`PLC_CTRL_OFF, 32'h0, 4'hf, `PLC_RESP_OKAY);
        link(1'b0, 1'b1, 1'b0);
        chk({31'h0, width_grant}, 32'h1, "free width change");
        wr(`PLC_CTRL_OFF, 32'h200, 4'hf, `PLC_RESP_OKAY);
        link(1'b0, 1'b1, 1'b0);
        chk({31'h0, width_grant}, 32'h0, "width change refused");
        link(1'b0, 1'b1, 1'b1);
        chk({31'h0, width_grant}, 32'h1, "reducing fix allowed");
        link(1'b0, 1'b0, 1'b1);
        chk({31'h0, width_grant}, 32'h0, "no request no grant");
    endtask : t_width

    // Mid-run reset must bring every link field back to zero
    task automatic t_reset();
        wr(`PLC_CTRL_OFF, 32'h3cb, 4'hf, `PLC_RESP_OKAY);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk({25'h0, link_ctrl}, 32'h0, "link fields after reset");
        chk({31'h0, clkreq_n}, 32'h0, "clock request after reset");
        rd(`PLC_CTRL_OFF, 32'h0, `PLC_RESP_OKAY);
    endtask : t_reset

    // ***********************************
    // Run control
    // ***********************************
    task automatic wrap_up();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_ctrl();
        t_cap();
        t_unmapped();
        t_clkreq();
        t_width();
        t_reset();
        wrap_up();
    end
endmodule : tb_top
